// >>> src/adcstf_pkg.sv
// shared constants and carrier types for the converter serial control block
package adcstf_pkg;
    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam logic [4:0] BIT_COUNT_END = 5'h10;   // sixteen serial clocks per frame
    localparam logic [4:0] CMD_BITS_END = 5'h04;    // command period length
    localparam logic [5:0] LONG_SAMPLE_END = 6'h30; // 48th falling edge ends long sampling
    localparam int CMD_MSB = 15;
    localparam int CMD_LSB = 12;
    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_SEL_LAST = 4'h7;     // 0..7 select analog input
    localparam logic [3:0] CMD_WRITE_CFG = 4'ha;
    localparam logic [3:0] CMD_TEST_FIRST = 4'hb;   // b..d select test voltages
    localparam logic [3:0] CMD_TEST_LAST = 4'hd;
    // ------------------------------------------------------------
    // configuration word fields and reset value
    // ------------------------------------------------------------
    localparam logic [11:0] CFG_RESET = 12'h800;
    localparam int CFG_TWOS_BIT = 10;
    localparam int CFG_SHORT_BIT = 9;
    localparam int CFG_PSEUDO_BIT = 5;
    // ------------------------------------------------------------
    // result coding
    // ------------------------------------------------------------
    localparam logic [13:0] RESULT_MSB_FLIP = 14'h2000; // binary to two's complement
    localparam logic [1:0] RESULT_PAD = 2'h0;
    // ------------------------------------------------------------
    // timing at 40 MHz
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    localparam int CONV_TIME_NS = 4500;
    localparam int CONV_CYCLES = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [7:0] CONV_COUNT = 8'(CONV_CYCLES);
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic cs_n;
        logic frame_sync;
        logic sclk;
        logic serial_in;
        logic conv_start_n;
    } adcstf_pins_t;
    typedef struct packed {
        logic [3:0] mux_sel;
        logic test_sel;
        logic pseudo_diff;
    } adcstf_mux_t;
endpackage : adcstf_pkg

// >>> src/adcstf_sync.sv
// two-flop synchroniser for the asynchronous pin bundle
`timescale 1ns/1ps
`default_nettype none
module adcstf_sync
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pins in and sampled out
    input wire adcstf_pkg::adcstf_pins_t pins_i,
    output adcstf_pkg::adcstf_pins_t pins_o
);
    import adcstf_pkg::*;
    adcstf_pins_t meta_q;
    // ------------------------------------------------------------
    // two stages, idle levels at reset
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
            pins_o <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        end
        else
        begin
            meta_q <= pins_i;
            pins_o <= meta_q;
        end
    end
endmodule : adcstf_sync
`default_nettype wire

// >>> src/adcstf_top.sv
// serial trigger, framing and result coding for the converter control block
// Overview of operation
// RQ1 - chip select high: output tri-stated, frame sync, clock and input ignored
// RQ2 - frame sync rising edge starts operation; chip select may stay low
// RQ3 - host waits half a clock after chip select falls before frame sync
// RQ4 - in frame sync mode the first output bit follows frame sync rise
// RQ5 - frame sync rise starting an operation releases interrupt high
// RQ6 - host holds start pin low for at least the sampling time
// RQ7 - host waits a conversion time before lowering start pin again
// RQ8 - start pin rise: end of conversion low now, interrupt after conversion
// RQ9 - start pin fall releases the interrupt high
// RQ10 - host keeps serial clock within 25 or 10 MHz by mode
// RQ11 - input word: 4-bit command on top, 12 bits data or zeros
// RQ12 - output word: 14-bit result on top, two low bits meaningless
// RQ13 - straight binary: zero 0000h, mid 2000h, full 3fffh
// RQ14 - two's complement: zero 2000h, mid 0000h, full 1fffh
// RQ15 - command selects one of eight inputs or three test voltages
// RQ16 - pseudodifferential mode pairs channels, halving usable inputs
// RQ17 - frame sync low at chip select fall waits for frame sync rise
// RQ18 - bit counter reset at start; output tri-states at sixteen
// RQ19 - first four clocks are the command period
// RQ20 - long sampling ends at 48th falling edge, then conversion, interrupt
// RQ21 - configuration bit selects straight binary or two's complement coding
// RQ22 - shift out on rising edge, latch input on falling edge
`timescale 1ns/1ps
`default_nettype none
module adcstf_top
(
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_I,
    // serial link pins
    input wire logic CS_N_I,
    input wire logic FRAME_SYNC_I,
    input wire logic SCLK_I,
    input wire logic SERIAL_IN_I,
    output logic SERIAL_OUT_O,
    output logic SERIAL_OUT_OE_O,
    // hardware start and completion
    input wire logic CONV_START_N_I,
    output logic EOC_N_O,
    output logic INT_N_O,
    // converter core side
    input wire logic [13:0] RAW_RESULT_I,
    output adcstf_pkg::adcstf_mux_t MUX_O,
    output logic SAMPLE_O,
    output logic [11:0] CONFIG_O
);
    import adcstf_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} adcstf_state_t;

    adcstf_pins_t pin_s;
    logic cs_n_d1_q, fsync_d1_q, sclk_d1_q, cst_d1_q;
    logic armed_fsync_q, active_q;
    logic [4:0] bit_cnt_q;
    logic [5:0] fall_cnt_q;
    logic [15:0] in_shift_q;
    logic [15:0] out_shift_q;
    logic [13:0] last_result_q;
    logic [7:0] conv_cnt_q;
    logic hw_conv_q;
    adcstf_state_t state_q;
    logic cs_fall, fsync_rise, sclk_rise, sclk_fall, cst_rise, cst_fall, start_op;
    logic [15:0] out_word;
    logic [3:0] cmd_now;
    logic cmd_select;
    logic conv_done;

    // ------------------------------------------------------------
    // pin synchronisation and edge finding
    // ------------------------------------------------------------
    adcstf_sync u_sync
    (
        .clk_i(CLOCK_I),
        .rst_i(RST_I),
        .pins_i('{CS_N_I, FRAME_SYNC_I, SCLK_I, SERIAL_IN_I, CONV_START_N_I}),
        .pins_o(pin_s)
    );

    // delayed copies of the synchronised pins
    always_ff @(posedge CLOCK_I)
    begin
        if (RST_I)
        begin
            cs_n_d1_q <= 1'b1;
            fsync_d1_q <= 1'b1;
            sclk_d1_q <= 1'b0;
            cst_d1_q <= 1'b1;
        end
        else
        begin
            cs_n_d1_q <= pin_s.cs_n;
            fsync_d1_q <= pin_s.frame_sync;
            sclk_d1_q <= pin_s.sclk;
            cst_d1_q <= pin_s.conv_start_n;
        end
    end

    // RQ1 frame sync and serial clock edges only count while selected
    assign cs_fall = cs_n_d1_q && !pin_s.cs_n;
    assign fsync_rise = !fsync_d1_q && pin_s.frame_sync && !pin_s.cs_n;
    assign sclk_rise = !sclk_d1_q && pin_s.sclk && !pin_s.cs_n && active_q;
    assign sclk_fall = sclk_d1_q && !pin_s.sclk && !pin_s.cs_n && active_q;
    assign cst_rise = !cst_d1_q && pin_s.conv_start_n;
    assign cst_fall = cst_d1_q && !pin_s.conv_start_n;
    // RQ17 start source chosen by frame sync level at select
    assign start_op = (cs_fall && pin_s.frame_sync) || (fsync_rise && armed_fsync_q);

    // ------------------------------------------------------------
    // trigger selection and frame activity
    // ------------------------------------------------------------
    // RQ2 frame sync trigger arming
    always_ff @(posedge CLOCK_I)
    begin
        if (RST_I)
        begin
            armed_fsync_q <= 1'b1;
            active_q <= 1'b0;
        end
        else if (pin_s.cs_n)
        begin
            armed_fsync_q <= 1'b1;
            active_q <= 1'b0;
        end
        else
        begin
            if (cs_fall)
            begin
                armed_fsync_q <= !pin_s.frame_sync;
            end
            if (start_op)
            begin
                active_q <= 1'b1;
            end
            else if (sclk_fall && bit_cnt_q == BIT_COUNT_END - 5'h01)
            begin
                active_q <= 1'b0;
            end
        end
    end

    // RQ18 bit counter cleared at start
    always_ff @(posedge CLOCK_I)
    begin
        if (RST_I || start_op)
        begin
            bit_cnt_q <= 5'h00;
        end
        else if (sclk_fall && bit_cnt_q != BIT_COUNT_END)
        begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // input shifting and command decode
    // ------------------------------------------------------------
    // RQ22 input latched on falling edge
    always_ff @(posedge CLOCK_I)
    begin
        if (RST_I || start_op)
        begin
            in_shift_q <= 16'h0000;
        end
        else if (sclk_fall)
        begin
            in_shift_q <= {in_shift_q[14:0], pin_s.serial_in};
        end
    end

    // RQ19 command complete after four clocks
    assign cmd_now = in_shift_q[3:0];
    // select and test commands start sampling; a config write does not
    assign cmd_select = (cmd_now <= CMD_SEL_LAST)
                        || (cmd_now >= CMD_TEST_FIRST && cmd_now <= CMD_TEST_LAST);

    // RQ11 command on top, config data below
    always_ff @(posedge CLOCK_I)
    begin
        if (RST_I)
        begin
            CONFIG_O <= CFG_RESET;
            MUX_O <= '0;
        end
        else if (sclk_fall && bit_cnt_q == BIT_COUNT_END - 5'h01
                 && in_shift_q[14:11] == CMD_WRITE_CFG)
        begin
            CONFIG_O <= {in_shift_q[10:0], pin_s.serial_in};
        end
        else if (active_q && bit_cnt_q == CMD_BITS_END && cmd_select)
        begin
            // RQ15 select input or test voltage
            if (cmd_now <= CMD_SEL_LAST)
            begin
                // RQ16 pair channels in pseudodifferential mode
                MUX_O.mux_sel <= CONFIG_O[CFG_PSEUDO_BIT] ? {cmd_now[3:1], 1'b0} : cmd_now;
                MUX_O.test_sel <= 1'b0;
            end
            else if (cmd_now >= CMD_TEST_FIRST)
            begin
                MUX_O.mux_sel <= cmd_now;
                MUX_O.test_sel <= 1'b1;
            end
            MUX_O.pseudo_diff <= CONFIG_O[CFG_PSEUDO_BIT];
        end
    end

    // ------------------------------------------------------------
    // output coding and shifting
    // ------------------------------------------------------------
    // RQ21 coding chosen by configuration
    // RQ13 straight binary passes through; RQ14 top bit flipped
    // RQ12 result on top, pad below
    assign out_word = {CONFIG_O[CFG_TWOS_BIT] ? (last_result_q ^ RESULT_MSB_FLIP)
                       : last_result_q, RESULT_PAD};

    // RQ4 msb loaded on the start edge
    // RQ22 following bits shift on rising edges
    always_ff @(posedge CLOCK_I)
    begin
        if (RST_I)
        begin
            out_shift_q <= 16'h0000;
        end
        else if (start_op)
        begin
            out_shift_q <= out_word;
        end
        else if (sclk_rise && bit_cnt_q != 5'h00)
        begin
            out_shift_q <= {out_shift_q[14:0], 1'b0};
        end
    end

    // RQ1 tri-state when deselected; RQ18 tri-state at sixteen
    always_ff @(posedge CLOCK_I)
    begin
        if (RST_I)
        begin
            SERIAL_OUT_O <= 1'b0;
            SERIAL_OUT_OE_O <= 1'b0;
        end
        else
        begin
            SERIAL_OUT_O <= start_op ? out_word[15] : out_shift_q[15];
            SERIAL_OUT_OE_O <= !pin_s.cs_n && (start_op || (active_q && bit_cnt_q != BIT_COUNT_END));
        end
    end

    // ------------------------------------------------------------
    // sampling and conversion sequencing
    // ------------------------------------------------------------
    assign conv_done = (state_q == ST_CONVERT) && (conv_cnt_q == 8'h01);

    // long-mode falling edge counter, cleared at each start, runs on past the frame end
    always_ff @(posedge CLOCK_I)
    begin
        if (RST_I || start_op)
        begin
            fall_cnt_q <= 6'h00;
        end
        else if (sclk_dl_fall_ok(sclk_d1_q, pin_s.sclk, pin_s.cs_n) && fall_cnt_q != LONG_SAMPLE_END)
        begin
            fall_cnt_q <= fall_cnt_q + 6'h01;
        end
    end

    // state of sampling and conversion
    always_ff @(posedge CLOCK_I)
    begin
        if (RST_I)
        begin
            state_q <= ST_IDLE;
            conv_cnt_q <= 8'h00;
            hw_conv_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (cst_fall || (active_q && bit_cnt_q == CMD_BITS_END
                                     && cmd_select))
                    begin
                        state_q <= ST_SAMPLE;
                        hw_conv_q <= cst_fall;
                    end
                end
                ST_SAMPLE:
                begin
                    // RQ8 start pin rise begins conversion
                    // RQ20 long sampling ends at 48th fall
                    if ((hw_conv_q && cst_rise)
                        || (!hw_conv_q && CONFIG_O[CFG_SHORT_BIT] && bit_cnt_q == BIT_COUNT_END)
                        || (!hw_conv_q && !CONFIG_O[CFG_SHORT_BIT]
                            && fall_cnt_q == LONG_SAMPLE_END))
                    begin
                        state_q <= ST_CONVERT;
                        conv_cnt_q <= CONV_COUNT;
                    end
                end
                ST_CONVERT:
                begin
                    conv_cnt_q <= conv_cnt_q - 8'h01;
                    if (conv_done)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // result capture, sample strobe, completion outputs
    always_ff @(posedge CLOCK_I)
    begin
        if (RST_I)
        begin
            last_result_q <= 14'h0000;
            SAMPLE_O <= 1'b0;
            EOC_N_O <= 1'b1;
            INT_N_O <= 1'b1;
        end
        else
        begin
            SAMPLE_O <= (state_q == ST_SAMPLE);
            if (conv_done)
            begin
                last_result_q <= RAW_RESULT_I;
            end
            // RQ8 end of conversion low while converting
            EOC_N_O <= !((state_q == ST_SAMPLE && hw_conv_q && cst_rise)
                         || (state_q == ST_CONVERT && !conv_done));
            // RQ8 interrupt one conversion time later; completion wins a tie
            if (conv_done)
            begin
                INT_N_O <= 1'b0;
            end
            // RQ5 RQ9 new start releases interrupt
            else if (start_op || cst_fall)
            begin
                INT_N_O <= 1'b1;
            end
        end
    end

    // falling edge of serial clock while selected, regardless of frame
    function automatic logic sclk_dl_fall_ok(input logic prev, input logic now, input logic csn);
        sclk_dl_fall_ok = prev && !now && !csn;
    endfunction : sclk_dl_fall_ok
endmodule : adcstf_top
`default_nettype wire

// >>> tb/adc_serial_trigger_and_format_test.sv
// self-checking bench for the converter serial control block
`timescale 1ns/1ps
`default_nettype none
module adc_serial_trigger_and_format_test;
    import adcstf_pkg::*;
    localparam int SAMPLE_CYCLES = 40; // sampling hold, plain default
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start_n = 1'b1;
    logic [13:0] raw = 14'h0000;
    logic cs_n, frame_sync, sclk, serial_in, serial_out, oe, eoc_n, int_n, sample;
    logic [11:0] cfg;
    adcstf_mux_t mux;
    logic oe_seen = 1'b0;
    int mismatches = 0;
    int checks_done = 0;
    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        if (oe === 1'b1)
            oe_seen <= 1'b1;
    end
    adcstf_top dut_u (.CLOCK_I(clk), .RST_I(rst), .CS_N_I(cs_n), .FRAME_SYNC_I(frame_sync),
        .SCLK_I(sclk), .SERIAL_IN_I(serial_in), .SERIAL_OUT_O(serial_out),
        .SERIAL_OUT_OE_O(oe), .CONV_START_N_I(start_n), .EOC_N_O(eoc_n), .INT_N_O(int_n),
        .RAW_RESULT_I(raw), .MUX_O(mux), .SAMPLE_O(sample), .CONFIG_O(cfg));
    // undriven line toggles so the host never reads a stale bit
    adcstf_host host_u (.clk_i(clk), .cs_n_o(cs_n), .frame_sync_o(frame_sync),
        .sclk_o(sclk), .serial_in_o(serial_in), .serial_out_i(oe ? serial_out : clk));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    task automatic do_reset();
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("config", 16'h0800, {4'h0, cfg});
        check("eoc_int", 16'h0003, {14'h0, eoc_n, int_n});
        repeat (3) @(posedge clk);
        $display("done reset");
    endtask : do_reset
    task automatic wait_int();
        int n = 0;
        while (int_n !== 1'b0 && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        check("int_n", 16'h0000, {15'h0, int_n});
    endtask : wait_int
    task automatic select(input logic [3:0] cmd, input logic fsync_lvl, output logic [15:0] d);
        host_u.frame({cmd, 12'h000}, 1'b1, fsync_lvl, d);
        check("int_n", 16'h0001, {15'h0, int_n});
        check("oe", 16'h0000, {15'h0, oe});
        wait_int();
    endtask : select
    task automatic write_cfg(input logic [11:0] val);
        logic [15:0] d;
        host_u.frame({CMD_WRITE_CFG, val}, 1'b1, 1'b0, d);
        check("config", {4'h0, val}, {4'h0, cfg});
    endtask : write_cfg
    task automatic t_desel();
        logic [15:0] d;
        oe_seen = 1'b0;
        host_u.frame(16'ha123, 1'b0, 1'b0, d);
        check("oe_seen", 16'h0000, {15'h0, oe_seen});
        check("config", 16'h0800, {4'h0, cfg});
        $display("done deselect");
    endtask : t_desel
    task automatic t_format();
        logic [15:0] d;
        logic [13:0] vals [3] = '{14'h0000, 14'h2000, 14'h3fff};
        logic [13:0] twos [3] = '{14'h2000, 14'h0000, 14'h1fff};
        for (int f = 0; f < 2; f++)
        begin
            write_cfg(f == 0 ? 12'ha00 : 12'he00);
            for (int k = 0; k < 3; k++)
            begin
                raw <= vals[k];
                select(4'h0, f[0], d);
                select(4'h0, f[0], d);
                check("result", {(f == 0 ? vals[k] : twos[k]), 2'h0}, {d[15:2], 2'h0});
            end
        end
        $display("done format");
    endtask : t_format
    task automatic t_mux();
        logic [15:0] d;
        logic [3:0] cmds [4] = '{4'h0, 4'h7, 4'hb, 4'hd};
        write_cfg(12'ha00);
        for (int k = 0; k < 4; k++)
        begin
            select(cmds[k], 1'b0, d);
            check("test_sel", {15'h0, cmds[k] > 4'h7}, {15'h0, mux.test_sel});
            if (k < 2)
                check("mux_sel", {12'h0, cmds[k]}, {12'h0, mux.mux_sel});
        end
        write_cfg(12'ha20);
        select(4'h3, 1'b0, d);
        check("pseudo", 16'h0005, {11'h0, mux.mux_sel, mux.pseudo_diff});
        $display("done mux");
    endtask : t_mux
    task automatic t_hw();
        int n = 0;
        // start held low for the sampling time
        start_n <= 1'b0;
        repeat (SAMPLE_CYCLES) @(posedge clk);
        check("sample", 16'h0001, {15'h0, sample});
        start_n <= 1'b1;
        while (eoc_n !== 1'b0 && n < 8)
        begin
            @(posedge clk);
            n++;
        end
        check("eoc_prompt", 16'h0001, {15'h0, n < 8});
        n = 0;
        while (int_n !== 1'b0 && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        check("int_delay", 16'h0001, {15'h0, n >= 178 && n <= 182});
        // next start only after the conversion
        start_n <= 1'b0;
        repeat (6) @(posedge clk);
        check("int_n", 16'h0001, {15'h0, int_n});
        // second pulse also lasts the sampling time
        repeat (SAMPLE_CYCLES - 6) @(posedge clk);
        start_n <= 1'b1;
        wait_int();
        $display("done hardware start");
    endtask : t_hw
    task automatic t_long();
        logic [15:0] d;
        // reset config is long sampling: clocks run on to the 48th fall
        host_u.tail_clocks = 32;
        select(4'h1, 1'b0, d);
        host_u.tail_clocks = 0;
        check("mux_sel", 16'h0001, {12'h0, mux.mux_sel});
        $display("done long sampling");
    endtask : t_long
    initial
    begin
        do_reset();
        t_desel();
        t_format();
        t_mux();
        do_reset();
        t_hw();
        t_long();
        finish_test();
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        mismatches++;
        finish_test();
    end
endmodule : adc_serial_trigger_and_format_test
`default_nettype wire

// >>> tb/adcstf_asserts.sv
// concurrent checks on the converter serial control block ports
`timescale 1ns/1ps
`default_nettype none
module adcstf_asserts
(
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic RST_I,
    // pins in
    input wire logic CS_N_I,
    input wire logic FRAME_SYNC_I,
    input wire logic SCLK_I,
    input wire logic CONV_START_N_I,
    // outputs watched
    input wire logic SERIAL_OUT_OE_O,
    input wire logic EOC_N_O,
    input wire logic INT_N_O,
    input wire logic SAMPLE_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    logic sclk_q;
    logic [4:0] falls_q;
    // count serial clock falls while the output is enabled
    always_ff @(posedge CLOCK_I)
    begin
        sclk_q <= SCLK_I;
        if (RST_I || !SERIAL_OUT_OE_O)
            falls_q <= 5'h00;
        else if (sclk_q && !SCLK_I)
            falls_q <= falls_q + 5'h01;
    end
    AST_DESEL_OFF: assert property (CS_N_I [*5] |-> !SERIAL_OUT_OE_O)
        else $error("output enabled while deselected");
    AST_FSYNC_START: assert property ($rose(FRAME_SYNC_I) && !CS_N_I |-> ##[2:6] SERIAL_OUT_OE_O)
        else $error("frame sync did not start output");
    AST_FSYNC_INT: assert property ($rose(FRAME_SYNC_I) && !CS_N_I |-> ##[2:6] INT_N_O)
        else $error("frame sync did not release interrupt");
    AST_START_EOC: assert property ($rose(CONV_START_N_I) |-> ##[2:5] !EOC_N_O)
        else $error("end of conversion late after start");
    AST_SAMPLE_END: assert property ($rose(CONV_START_N_I) |-> ##[2:5] !SAMPLE_O)
        else $error("sampling did not end at start rise");
    AST_INT_TIME: assert property ($fell(EOC_N_O) |-> ##[178:182] !INT_N_O)
        else $error("interrupt not one conversion time later");
    AST_INT_EARLY: assert property ($fell(INT_N_O) |-> !$past(EOC_N_O, 170))
        else $error("interrupt before conversion time");
    AST_START_FALL: assert property ($fell(CONV_START_N_I) |-> ##[2:6] INT_N_O)
        else $error("start fall did not release interrupt");
    AST_FRAME_END: assert property (falls_q == 5'h10 |-> ##[0:6] !SERIAL_OUT_OE_O)
        else $error("output still enabled after sixteen clocks");
    COV_INT: cover property ($fell(INT_N_O));
    COV_OE: cover property ($rose(SERIAL_OUT_OE_O));
    COV_EOC: cover property ($fell(EOC_N_O));
endmodule : adcstf_asserts
bind adcstf_top adcstf_asserts chk_u (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .CS_N_I(CS_N_I),
    .FRAME_SYNC_I(FRAME_SYNC_I), .SCLK_I(SCLK_I), .CONV_START_N_I(CONV_START_N_I),
    .SERIAL_OUT_OE_O(SERIAL_OUT_OE_O), .EOC_N_O(EOC_N_O), .INT_N_O(INT_N_O),
    .SAMPLE_O(SAMPLE_O));
`default_nettype wire

// >>> tb/adcstf_host.sv
// host serial port model driving the converter link
`timescale 1ns/1ps
`default_nettype none
module adcstf_host
(
    // clock
    input wire logic clk_i,
    // link pins
    output logic cs_n_o,
    output logic frame_sync_o,
    output logic sclk_o,
    output logic serial_in_o,
    input wire logic serial_out_i
);
    logic busy;
    int tail_clocks;
    initial
    begin
        busy = 1'b0;
        tail_clocks = 0;
        cs_n_o = 1'b1;
        frame_sync_o = 1'b0;
        sclk_o = 1'b0;
        serial_in_o = 1'b0;
    end
    // released data line keeps moving so stale bits never look valid
    always @(posedge clk_i)
    begin
        if (!busy)
            serial_in_o <= ~serial_in_o;
    end
    // one 16-bit frame; serial clock is 200 ns and still between frames
    task automatic frame(input logic [15:0] din, input logic sel, input logic fsync_lvl,
        output logic [15:0] dout);
        busy = 1'b1;
        // frame sync level at select picks the trigger
        frame_sync_o <= fsync_lvl;
        @(posedge clk_i);
        // select half a clock before frame sync
        if (!fsync_lvl)
            cs_n_o <= ~sel;
        repeat (4) @(posedge clk_i);
        for (int i = 15; i >= 0; i--)
        begin
            sclk_o <= 1'b1;
            serial_in_o <= din[i];
            @(posedge clk_i);
            if (i == 15 && fsync_lvl)
                cs_n_o <= ~sel;
            else
                frame_sync_o <= (i == 15) | fsync_lvl;
            repeat (3) @(posedge clk_i);
            sclk_o <= 1'b0;
            // sample mid-cycle, away from the edge that moves the output
            repeat (3) @(posedge clk_i);
            @(negedge clk_i);
            dout[i] = serial_out_i;
            @(posedge clk_i);
        end
        // extra clocks with select held, for long sampling
        repeat (tail_clocks)
        begin
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
        repeat (4) @(posedge clk_i);
        cs_n_o <= 1'b1;
        @(posedge clk_i);
        busy = 1'b0;
    endtask : frame
endmodule : adcstf_host
`default_nettype wire
